// ### bench/asfc_codec_bench.sv
// self-checking bench of the api frame codec
`timescale 1ns/1ns
module asfc_codec_bench import asfc_pkg::*;;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] api_mode_select = 2'h1;
    logic rx_fmt_explicit = 1'b0;
    logic rx_valid, rx_ready, tx_valid, tx_ready, frm_valid, rcv_known, rcv_ok;
    logic param_apply, param_queue, hdr_ready, snd_ready;
    logic [7:0] rx_data, tx_data, frame_type_identifier, rcv_id;
    logic frm_ready = 1'b0;
    logic stat_valid = 1'b0;
    logic hdr_valid = 1'b0;
    logic snd_valid = 1'b0;
    logic hold = 1'b0;
    logic [7:0] frame_specific_payload = 8'h00;
    asfc_word_t frm_word;
    asfc_stat_t stat_in = '0;
    asfc_hdr_t hdr_in = '0;
    asfc_word_t fq[$];
    int fail_count = 0;
    int check_count = 0;
    int ok_n = 0;
    int ap_n = 0;
    int qu_n = 0;
    always #4 core_clk = ~core_clk;
    asfc_codec #(.DEPTH(8)) u_asfc_codec (.core_clk, .resetn, .api_mode_select, .rx_fmt_explicit,
        .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready, .frm_valid, .frm_word,
        .frm_ready, .frame_type_identifier, .rcv_id, .rcv_known, .rcv_ok, .param_apply,
        .param_queue, .stat_valid, .stat_in, .hdr_valid, .hdr_in, .hdr_ready, .snd_valid,
        .frame_specific_payload, .snd_ready);
    asfc_host_model u_asfc_host_model (.core_clk, .resetn, .rx_valid, .rx_data, .rx_ready,
        .tx_valid, .tx_data, .tx_ready);
    // gather delivered words and pulses where they are settled
    always @(negedge core_clk) begin
        if (frm_valid === 1'b1 && frm_ready) fq.push_back(frm_word);
        if (rcv_ok === 1'b1) ok_n++;
        if (param_apply === 1'b1) ap_n++;
        if (param_queue === 1'b1) qu_n++;
    end
    // user side stalls every other cycle, or fully while held
    always @(posedge core_clk) frm_ready <= !hold && !frm_ready;
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask : chk
    task automatic expect_frm(input logic [7:0] d[$]);
        for (int i = 0; i < 300 && fq.size() < d.size(); i++) @(posedge core_clk);
        chk("word count", d.size(), fq.size());
        foreach (d[k]) if (k < fq.size()) chk("word", {d[k], k == 0, k == d.size() - 1}, fq[k]);
        fq.delete();
    endtask : expect_frm
    task automatic expect_tx(input logic [7:0] e[$]);
        for (int i = 0; i < 300 && u_asfc_host_model.txq.size() < e.size(); i++) @(posedge core_clk);
        repeat (20) @(posedge core_clk);
        chk("tx count", e.size(), u_asfc_host_model.txq.size());
        foreach (e[k]) if (k < u_asfc_host_model.txq.size()) chk("tx byte", e[k], u_asfc_host_model.txq[k]);
        u_asfc_host_model.txq.delete();
    endtask : expect_tx
    task automatic s_plain();
        logic [7:0] d[$];
        int n;
        hold <= 1'b1;
        n = ok_n;
        d = {8'h10, 8'h01, 8'h7e, 8'h13};
        u_asfc_host_model.put(8'h55, 1'b0);
        u_asfc_host_model.put(8'h00, 1'b0);
        u_asfc_host_model.send(d, 1'b0, 1'b0);
        repeat (10) @(posedge core_clk);
        chk("stalled", 2'b10, {frm_valid, rx_ready});
        hold <= 1'b0;
        expect_frm(d);
        chk("ok pulses", n + 1, ok_n);
        chk("id", 8'h01, rcv_id);
    endtask : s_plain
    task automatic s_types();
        logic [7:0] t[$];
        logic [7:0] d[$];
        int a;
        int q;
        t = {8'h08, 8'h09, 8'h10, 8'h11, 8'h17, 8'h88, 8'h8a, 8'h8b, 8'h90, 8'h91, 8'h95, 8'h97, 8'h42};
        a = ap_n;
        q = qu_n;
        foreach (t[i]) begin
            d = {t[i], 8'h07};
            u_asfc_host_model.send(d, 1'b0, 1'b0);
            expect_frm(d);
            chk("type", t[i], frame_type_identifier);
            chk("known", t[i] != 8'h42, rcv_known);
        end
        chk("apply", a + 1, ap_n);
        chk("queue", q + 1, qu_n);
    endtask : s_types
    task automatic s_drop();
        logic [7:0] d[$];
        int n;
        n = ok_n;
        d = {8'h10, 8'h02, 8'h33};
        u_asfc_host_model.send(d, 1'b0, 1'b1);
        d = {8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
        u_asfc_host_model.send(d, 1'b0, 1'b0);
        d = {8'h10, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
        u_asfc_host_model.send(d, 1'b0, 1'b0);
        expect_frm(d);
        chk("ok pulses", n + 1, ok_n);
    endtask : s_drop
    task automatic s_esc();
        logic [7:0] d[$];
        int n;
        api_mode_select <= 2'h2;
        n = ok_n;
        u_asfc_host_model.put(8'h7e, 1'b0);
        u_asfc_host_model.put(8'h00, 1'b0);
        u_asfc_host_model.put(8'h05, 1'b0);
        d = {8'h10, 8'h11, 8'h7e, 8'h7d, 8'h13, 8'h20};
        u_asfc_host_model.send(d, 1'b1, 1'b0);
        expect_frm(d);
        chk("ok pulses", n + 1, ok_n);
    endtask : s_esc
    task automatic s_stat(input logic [7:0] id, input logic [7:0] code);
        logic [7:0] e[$];
        logic [7:0] d[$];
        d = {8'h8b, id, code};
        u_asfc_host_model.build(d, 1'b1, 1'b0);
        e = u_asfc_host_model.lq;
        if (id == 8'h00) e.delete();
        u_asfc_host_model.slow <= 1'b1;
        stat_in <= '{fid: id, code: code};
        stat_valid <= 1'b1;
        @(posedge core_clk);
        stat_valid <= 1'b0;
        expect_tx(e);
    endtask : s_stat
    task automatic s_user(input asfc_hdr_t h, input logic [7:0] p[$], input logic [7:0] e[$]);
        logic ok;
        hdr_in <= h;
        hdr_valid <= 1'b1;
        do begin
            @(negedge core_clk);
            ok = hdr_ready;
            @(posedge core_clk);
        end while (!ok);
        hdr_valid <= 1'b0;
        foreach (p[i]) begin
            frame_specific_payload <= p[i];
            snd_valid <= 1'b1;
            do begin
                @(negedge core_clk);
                ok = snd_ready;
                @(posedge core_clk);
            end while (!ok);
        end
        snd_valid <= 1'b0;
        expect_tx(e);
    endtask : s_user
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    initial begin
        logic [7:0] e[$];
        logic [7:0] p[$];
        repeat (10) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        s_plain();
        s_types();
        s_drop();
        s_esc();
        s_stat(8'h00, 8'h01);
        s_stat(8'h7d, 8'h11);
        api_mode_select <= 2'h1;
        rx_fmt_explicit <= 1'b1;
        p = {8'h91, 8'h05, 8'haa, 8'hbb};
        u_asfc_host_model.build(p, 1'b0, 1'b0);
        e = u_asfc_host_model.lq;
        p = {8'haa, 8'hbb};
        s_user('{len: 16'h0004, ftype: 8'h90, fid: 8'h05, remote_ok: 1'b1}, p, e);
        e.delete();
        p = {8'hcc};
        s_user('{len: 16'h0003, ftype: 8'h97, fid: 8'h05, remote_ok: 1'b0}, p, e);
        s_user('{len: 16'h0003, ftype: 8'h88, fid: 8'h00, remote_ok: 1'b1}, p, e);
        // plain format select and reserved bytes sent unescaped in plain mode
        rx_fmt_explicit <= 1'b0;
        p = {8'h90, 8'h7e, 8'h11};
        u_asfc_host_model.build(p, 1'b0, 1'b0);
        e = u_asfc_host_model.lq;
        p = {8'h11};
        s_user('{len: 16'h0003, ftype: 8'h91, fid: 8'h7e, remote_ok: 1'b1}, p, e);
        give_verdict();
    end
    // cut a hang short well beyond the expected run
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule : asfc_codec_bench

// ### bench/asfc_host_model.sv
// host side model: feeds line bytes to the codec and gathers what it sends
`timescale 1ns/1ns
`include "asfc_consts.svh"
module asfc_host_model (
    input wire logic core_clk,
    input wire logic resetn,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic take = 1'b0;
    logic [7:0] take_d = 8'h00;
    logic [7:0] lq[$];
    logic [7:0] txq[$];
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end
    task automatic add(input logic [7:0] b, input logic esc);
        if (esc && (b == `ASFC_SOF || b == `ASFC_ESC || b == `ASFC_XON || b == `ASFC_XOFF)) begin
            lq.push_back(`ASFC_ESC);
            lq.push_back(b ^ `ASFC_XOR);
        end else begin
            lq.push_back(b);
        end
    endtask : add
    task automatic build(input logic [7:0] d[$], input logic esc, input logic bad);
        logic [7:0] sum;
        logic [15:0] len;
        sum = 8'h00;
        len = 16'(d.size());
        lq.delete();
        lq.push_back(`ASFC_SOF);
        add(len[15:8], esc);
        add(len[7:0], esc);
        foreach (d[i]) begin
            add(d[i], esc);
            sum = sum + d[i];
        end
        add((`ASFC_CK_OK - sum) ^ {7'h00, bad}, esc);
    endtask : build
    // one line byte, held until taken; released line shows the inverse
    task automatic put(input logic [7:0] b, input logic last);
        logic ok;
        rx_valid <= 1'b1;
        rx_data <= b;
        do begin
            @(negedge core_clk);
            ok = rx_ready;
            @(posedge core_clk);
        end while (!ok);
        if (last) begin
            rx_valid <= 1'b0;
            rx_data <= ~b;
        end
    endtask : put
    task automatic send(input logic [7:0] d[$], input logic esc, input logic bad);
        build(d, esc, bad);
        foreach (lq[i]) put(lq[i], i == lq.size() - 1);
    endtask : send
    // bytes kept raw, unknown types never stop the host
    always @(negedge core_clk) begin
        take = tx_valid && tx_ready && resetn;
        take_d = tx_data;
    end
    // collect sent bytes, stall every other cycle when slow
    always @(posedge core_clk) begin
        if (take) txq.push_back(take_d);
        tx_ready <= slow ? !tx_ready : 1'b1;
    end
endmodule : asfc_host_model

// ### verilog/asfc_codec.sv
// api frame decoder and encoder between uart byte streams and the user side
`timescale 1ns/1ns
`include "asfc_consts.svh"
module asfc_codec import asfc_pkg::*; #(
    parameter int DEPTH = 64
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [1:0] api_mode_select,
    input wire logic rx_fmt_explicit,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic frm_valid,
    output asfc_word_t frm_word,
    input wire logic frm_ready,
    output logic [7:0] frame_type_identifier,
    output logic [7:0] rcv_id,
    output logic rcv_known,
    output logic rcv_ok,
    output logic param_apply,
    output logic param_queue,
    input wire logic stat_valid,
    input wire asfc_stat_t stat_in,
    input wire logic hdr_valid,
    input wire asfc_hdr_t hdr_in,
    output logic hdr_ready,
    input wire logic snd_valid,
    input wire logic [7:0] frame_specific_payload,
    output logic snd_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    initial begin
        if (DEPTH < 2 || DEPTH > 65535) begin
            $error("DEPTH out of range");
        end
    end

    // shared mode decode
    wire esc_mode = api_mode_select == `ASFC_MODE_ESC;

    // ---------------- receiver ----------------
    asfc_rst_t r_st_r;
    logic r_esc_r;
    logic [7:0] len_hi_r;
    logic [15:0] r_len_r;
    logic [15:0] r_idx_r;
    logic [7:0] r_sum_r;
    logic [7:0] mem [0:DEPTH-1];
    logic ok_r, apply_r, queue_r, known_r;
    logic [7:0] type_r, id_r;

    // line byte handling, escape removal
    wire rx_take = rx_valid && rx_ready;
    wire rx_sof = rx_data == `ASFC_SOF;
    wire rx_escb = esc_mode && rx_data == `ASFC_ESC && !r_esc_r;
    wire [7:0] rx_byte = r_esc_r ? (rx_data ^ `ASFC_XOR) : rx_data;
    wire rx_abort = esc_mode && rx_sof && r_st_r != ASFC_R_HUNT && r_st_r != ASFC_R_DLV;
    wire [15:0] len_full = {len_hi_r, rx_byte};
    wire [7:0] sum_nxt = r_sum_r + rx_byte;
    wire len_bad = len_full == 16'h0000 || len_full > 16'(DEPTH);
    wire [7:0] t0 = mem[0];
    assign rx_ready = r_st_r != ASFC_R_DLV;

    // known frame type decode
    wire t_known = t0 == `ASFC_T_AT || t0 == `ASFC_T_ATQ || t0 == `ASFC_T_TXREQ
        || t0 == `ASFC_T_EXPL || t0 == `ASFC_T_RAT || t0 == `ASFC_T_ATRSP
        || t0 == `ASFC_T_MSTAT || t0 == `ASFC_T_TXSTAT || t0 == `ASFC_T_RXD
        || t0 == `ASFC_T_RXDX || t0 == `ASFC_T_IOS || t0 == `ASFC_T_RATRSP;

    // delivery into the two-entry buffer
    logic [1:0] b_cnt_r;
    logic b_wp_r, b_rp_r;
    asfc_word_t b_mem [0:1];
    wire b_in_ready = b_cnt_r != 2'h2;
    wire b_push = r_st_r == ASFC_R_DLV && b_in_ready;
    wire b_pop = frm_valid && frm_ready;
    wire dlv_last = r_idx_r == r_len_r - 16'h0001;
    asfc_word_t b_in;
    assign b_in = '{data: mem[r_idx_r[AW-1:0]], first: r_idx_r == 16'h0000, last: dlv_last};

    // frame assembly state machine
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            r_st_r <= ASFC_R_HUNT;
            r_esc_r <= 1'b0;
            len_hi_r <= 8'h00;
            r_len_r <= 16'h0000;
            r_idx_r <= 16'h0000;
            r_sum_r <= 8'h00;
        end else if (b_push) begin
            r_idx_r <= r_idx_r + 16'h0001;
            if (dlv_last) begin
                r_st_r <= ASFC_R_HUNT;
            end
        end else if (rx_take) begin
            r_esc_r <= rx_escb;
            if (rx_abort) begin
                r_st_r <= ASFC_R_LH;
                r_esc_r <= 1'b0;
            end else if (!rx_escb) begin
                case (r_st_r)
                    ASFC_R_HUNT: begin
                        if (rx_sof) begin
                            r_st_r <= ASFC_R_LH;
                        end
                    end
                    ASFC_R_LH: begin
                        len_hi_r <= rx_byte;
                        r_st_r <= ASFC_R_LL;
                    end
                    ASFC_R_LL: begin
                        r_len_r <= len_full;
                        r_idx_r <= 16'h0000;
                        r_sum_r <= 8'h00;
                        r_st_r <= len_bad ? ASFC_R_HUNT : ASFC_R_DATA;
                    end
                    ASFC_R_DATA: begin
                        r_sum_r <= sum_nxt;
                        r_idx_r <= r_idx_r + 16'h0001;
                        if (r_idx_r == r_len_r - 16'h0001) begin
                            r_st_r <= ASFC_R_CK;
                        end
                    end
                    ASFC_R_CK: begin
                        r_idx_r <= 16'h0000;
                        r_st_r <= (sum_nxt == `ASFC_CK_OK) ? ASFC_R_DLV : ASFC_R_HUNT;
                    end
                    default: begin
                        r_st_r <= ASFC_R_HUNT;
                    end
                endcase
            end
        end
    end

    // payload store, indexed by data position
    always_ff @(posedge core_clk) begin
        if (rx_take && !rx_escb && !rx_abort && r_st_r == ASFC_R_DATA) begin
            mem[r_idx_r[AW-1:0]] <= rx_byte;
        end
    end

    // frame report pulses, only for verified frames
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ok_r <= 1'b0;
            apply_r <= 1'b0;
            queue_r <= 1'b0;
            known_r <= 1'b0;
            type_r <= 8'h00;
            id_r <= 8'h00;
        end else begin
            ok_r <= b_push && r_idx_r == 16'h0000;
            apply_r <= b_push && r_idx_r == 16'h0000 && t0 == `ASFC_T_AT;
            queue_r <= b_push && r_idx_r == 16'h0000 && t0 == `ASFC_T_ATQ;
            if (b_push && r_idx_r == 16'h0000) begin
                // first byte is the frame type
                type_r <= t0;
                id_r <= (r_len_r > 16'h0001) ? mem[1] : 8'h00;
                known_r <= t_known;
            end
        end
    end
    assign rcv_ok = ok_r;
    assign param_apply = apply_r;
    assign param_queue = queue_r;
    assign rcv_known = known_r;
    assign frame_type_identifier = type_r;
    assign rcv_id = id_r;

    // two-entry buffer toward the frame consumer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            b_cnt_r <= 2'h0;
            b_wp_r <= 1'b0;
            b_rp_r <= 1'b0;
        end else begin
            b_cnt_r <= b_cnt_r + {1'b0, b_push} - {1'b0, b_pop};
            b_wp_r <= b_wp_r ^ b_push;
            b_rp_r <= b_rp_r ^ b_pop;
        end
    end
    always_ff @(posedge core_clk) begin
        if (b_push) begin
            b_mem[b_wp_r] <= b_in;
        end
    end
    assign frm_valid = b_cnt_r != 2'h0;
    assign frm_word = b_mem[b_rp_r];

    // ---------------- encoder ----------------
    asfc_est_t e_st_r;
    logic [15:0] e_len_r, e_idx_r;
    logic [7:0] e_sum_r, e_type_r, e_id_r, e_code_r, esc_val_r, tx_data_r;
    logic e_stat_r, e_drop_r, esc_pend_r, tx_valid_r;
    logic stat_pend_r;
    asfc_stat_t stat_r;

    // header decode: response suppression and format select
    wire h_resp = hdr_in.ftype == `ASFC_T_ATRSP || hdr_in.ftype == `ASFC_T_RATRSP
        || hdr_in.ftype == `ASFC_T_TXSTAT;
    // zero id on a response type or unheard remote drops the frame
    wire h_drop = (h_resp && hdr_in.fid == 8'h00) || hdr_in.len < 16'h0002
        || (hdr_in.ftype == `ASFC_T_RATRSP && !hdr_in.remote_ok);
    wire h_rxd = hdr_in.ftype == `ASFC_T_RXD || hdr_in.ftype == `ASFC_T_RXDX;
    wire [7:0] h_type = h_rxd ? (rx_fmt_explicit ? `ASFC_T_RXDX : `ASFC_T_RXD) : hdr_in.ftype;
    assign hdr_ready = e_st_r == ASFC_E_IDLE && !stat_pend_r;

    // next raw byte, checksum is 0xff minus sum
    wire e_user = e_st_r == ASFC_E_BODY && e_idx_r > 16'h0001 && !e_stat_r;
    wire [7:0] e_body = (e_idx_r == 16'h0000) ? e_type_r : (e_idx_r == 16'h0001) ? e_id_r
        : e_stat_r ? e_code_r : frame_specific_payload;
    wire [7:0] e_raw = (e_st_r == ASFC_E_DLM) ? `ASFC_SOF : (e_st_r == ASFC_E_LH) ? e_len_r[15:8]
        : (e_st_r == ASFC_E_LL) ? e_len_r[7:0] : (e_st_r == ASFC_E_CK) ? (`ASFC_CK_OK - e_sum_r)
        : e_body;
    // reserved set, only in escape mode
    wire e_resv = e_raw == `ASFC_SOF || e_raw == `ASFC_ESC || e_raw == `ASFC_XON || e_raw == `ASFC_XOFF;
    wire e_need_esc = esc_mode && e_st_r != ASFC_E_DLM && e_resv;
    wire out_free = !tx_valid_r || tx_ready;
    wire e_have = e_st_r != ASFC_E_IDLE && !e_drop_r && (!e_user || snd_valid);
    wire e_step = out_free && !esc_pend_r && e_have;
    wire e_body_last = e_idx_r == e_len_r - 16'h0001;
    wire d_take = e_drop_r && snd_valid;
    assign snd_ready = e_user && (e_drop_r || e_step);

    // pending transmit status, set wins over start
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            stat_pend_r <= 1'b0;
            stat_r <= '0;
        end else if (stat_valid && stat_in.fid != 8'h00) begin
            stat_pend_r <= 1'b1;
            stat_r <= stat_in;
        end else if (e_st_r == ASFC_E_IDLE) begin
            stat_pend_r <= 1'b0;
        end
    end

    // encoder sequence
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            e_st_r <= ASFC_E_IDLE;
            e_len_r <= 16'h0000;
            e_idx_r <= 16'h0000;
            e_sum_r <= 8'h00;
            e_type_r <= 8'h00;
            e_id_r <= 8'h00;
            e_code_r <= 8'h00;
            e_stat_r <= 1'b0;
            e_drop_r <= 1'b0;
        end else if (e_st_r == ASFC_E_IDLE) begin
            e_idx_r <= 16'h0000;
            e_sum_r <= 8'h00;
            if (stat_pend_r) begin
                e_st_r <= ASFC_E_DLM;
                e_len_r <= `ASFC_STAT_LEN;
                e_type_r <= `ASFC_T_TXSTAT;
                e_id_r <= stat_r.fid;
                e_code_r <= stat_r.code;
                e_stat_r <= 1'b1;
                e_drop_r <= 1'b0;
            end else if (hdr_valid) begin
                e_len_r <= hdr_in.len;
                e_type_r <= h_type;
                e_id_r <= hdr_in.fid;
                e_stat_r <= 1'b0;
                e_drop_r <= h_drop;
                e_idx_r <= h_drop ? 16'h0002 : 16'h0000;
                e_st_r <= !h_drop ? ASFC_E_DLM : (hdr_in.len > 16'h0002) ? ASFC_E_BODY : ASFC_E_IDLE;
            end
        end else if (d_take) begin
            e_idx_r <= e_idx_r + 16'h0001;
            if (e_body_last) begin
                e_st_r <= ASFC_E_IDLE;
            end
        end else if (e_step) begin
            case (e_st_r)
                ASFC_E_DLM: e_st_r <= ASFC_E_LH;
                ASFC_E_LH: e_st_r <= ASFC_E_LL;
                ASFC_E_LL: e_st_r <= ASFC_E_BODY;
                ASFC_E_BODY: begin
                    e_sum_r <= e_sum_r + e_raw;
                    e_idx_r <= e_idx_r + 16'h0001;
                    if (e_body_last) begin
                        e_st_r <= ASFC_E_CK;
                    end
                end
                default: e_st_r <= ASFC_E_IDLE;
            endcase
        end
    end

    // line output register, escape then xored byte
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
            esc_pend_r <= 1'b0;
            esc_val_r <= 8'h00;
        end else if (e_step) begin
            tx_valid_r <= 1'b1;
            tx_data_r <= e_need_esc ? `ASFC_ESC : e_raw;
            esc_pend_r <= e_need_esc;
            esc_val_r <= e_raw;
        end else if (esc_pend_r && out_free) begin
            tx_valid_r <= 1'b1;
            tx_data_r <= esc_val_r ^ `ASFC_XOR;
            esc_pend_r <= 1'b0;
        end else if (tx_ready) begin
            tx_valid_r <= 1'b0;
        end
    end
    assign tx_valid = tx_valid_r;
    assign tx_data = tx_data_r;

    // ---------------- checks ----------------
    a_hunt_ignores: assert property (@(posedge core_clk) disable iff (!resetn)
        r_st_r == ASFC_R_HUNT && rx_take && !rx_sof |=> r_st_r == ASFC_R_HUNT)
        else $error("byte before delimiter not ignored");
    a_bad_frame_dropped: assert property (@(posedge core_clk) disable iff (!resetn)
        r_st_r == ASFC_R_CK && rx_take && !rx_escb && !rx_abort && sum_nxt != `ASFC_CK_OK
        |=> r_st_r == ASFC_R_HUNT ##1 !rcv_ok)
        else $error("bad checksum frame kept");
    a_good_frame_ok: assert property (@(posedge core_clk) disable iff (!resetn)
        r_st_r == ASFC_R_CK && rx_take && !rx_escb && !rx_abort && sum_nxt == `ASFC_CK_OK && b_in_ready
        |=> r_st_r == ASFC_R_DLV ##[1:3] rcv_ok)
        else $error("good frame not reported");
    a_escape_pair: assert property (@(posedge core_clk) disable iff (!resetn)
        tx_valid && tx_ready && esc_pend_r |=> tx_valid && tx_data == ($past(esc_val_r) ^ `ASFC_XOR))
        else $error("escape not followed by xored byte");
    a_plain_no_escape: assert property (@(posedge core_clk) disable iff (!resetn)
        api_mode_select == `ASFC_MODE_PLAIN && e_step |=> !esc_pend_r)
        else $error("escape in plain mode");
    a_oversize_abandon: assert property (@(posedge core_clk) disable iff (!resetn)
        r_st_r == ASFC_R_LL && rx_take && !rx_escb && !rx_abort && len_full > 16'(DEPTH)
        |=> r_st_r == ASFC_R_HUNT)
        else $error("oversize frame not abandoned");
    a_sof_restart: assert property (@(posedge core_clk) disable iff (!resetn)
        rx_take && rx_abort |=> r_st_r == ASFC_R_LH)
        else $error("mid-frame delimiter did not restart");
    a_zero_id_silent: assert property (@(posedge core_clk) disable iff (!resetn)
        stat_valid && stat_in.fid == 8'h00 && !stat_pend_r |=> !stat_pend_r)
        else $error("status queued for zero id");
    a_apply_type: assert property (@(posedge core_clk) disable iff (!resetn)
        param_apply |-> rcv_ok && frame_type_identifier == `ASFC_T_AT && !param_queue)
        else $error("apply without type 0x08 frame");
endmodule : asfc_codec

// ### verilog/asfc_consts.svh
// constants of the api serial frame codec
// Functional notes
// - receiver drops every byte until a 0x7e start delimiter arrives
// - incomplete frames or bad checksums are dropped whole, never acted on
// - mode 1 selects plain framing, mode 2 framing with escaping
// - escaped byte is 0x7d then the original byte xor 0x20
// - escaped set is exactly 0x7e, 0x7d, 0x11 and 0x13
// - length counts unescaped frame data only, no delimiter, length or checksum
// - multi-byte fields, length included, go most significant byte first
// - checksum is 0xff minus the low 8 bits of the data sum
// - frame accepted only if data plus checksum sums to 0xff
// - checksums use de-escaped values, never line bytes
// - first data byte is the frame type selecting payload meaning
// - twelve listed frame types are known, all others unsupported
// - request with frame id zero gets no response frame
// - every transmit request gets a status frame unless its id is zero; a second status arriving while one still waits replaces it
// - received-data frame type is 0x90 or 0x91 by configuration
// - no remote response frame when the remote never got the command
// - type 0x08 parameter command applies changes right after it runs
// - type 0x09 queues parameter values until 0x08 or apply arrives
`ifndef ASFC_CONSTS_SVH
`define ASFC_CONSTS_SVH
`define ASFC_SOF 8'h7e
`define ASFC_ESC 8'h7d
`define ASFC_XOR 8'h20
`define ASFC_XON 8'h11
`define ASFC_XOFF 8'h13
`define ASFC_CK_OK 8'hff
`define ASFC_MODE_PLAIN 2'h1
`define ASFC_MODE_ESC 2'h2
`define ASFC_T_AT 8'h08
`define ASFC_T_ATQ 8'h09
`define ASFC_T_TXREQ 8'h10
`define ASFC_T_EXPL 8'h11
`define ASFC_T_RAT 8'h17
`define ASFC_T_ATRSP 8'h88
`define ASFC_T_MSTAT 8'h8a
`define ASFC_T_TXSTAT 8'h8b
`define ASFC_T_RXD 8'h90
`define ASFC_T_RXDX 8'h91
`define ASFC_T_IOS 8'h95
`define ASFC_T_RATRSP 8'h97
`define ASFC_STAT_LEN 16'h0003
`endif

// ### verilog/asfc_pkg.sv
// types of the api serial frame codec
package asfc_pkg;
    typedef enum logic [2:0] {
        ASFC_R_HUNT = 3'h0, ASFC_R_LH = 3'h1, ASFC_R_LL = 3'h2,
        ASFC_R_DATA = 3'h3, ASFC_R_CK = 3'h4, ASFC_R_DLV = 3'h5
    } asfc_rst_t;
    typedef enum logic [2:0] {
        ASFC_E_IDLE = 3'h0, ASFC_E_DLM = 3'h1, ASFC_E_LH = 3'h2,
        ASFC_E_LL = 3'h3, ASFC_E_BODY = 3'h4, ASFC_E_CK = 3'h5
    } asfc_est_t;
    typedef struct packed {
        logic [7:0] data;
        logic first;
        logic last;
    } asfc_word_t;
    typedef struct packed {
        logic [15:0] len;
        logic [7:0] ftype;
        logic [7:0] fid;
        logic remote_ok;
    } asfc_hdr_t;
    typedef struct packed {
        logic [7:0] fid;
        logic [7:0] code;
    } asfc_stat_t;
endpackage : asfc_pkg
